// ==== core/gpio_port.sv ====
//Function
//- outputs held in latch, inputs unlatched
//- pins sampled in first bus state
//- latch updates in second bus state
//- lcd select bit drives segment data
//- port1 latch resets to all ones
//- port1 latch and pin read apart
//- segment pin read value undefined
//- port2 latch resets to all ones
//- dual clock uses oscillator pins
//- driven stop pin falling edge interrupts
//- port2 read bits 7..3 undefined; here they read as zero
//- stop mode floats stop pin
//- route select picks interrupt pin
//- port2 latch and pin read apart
`timescale 1ns/1ps
module gpio_port
  import gpio_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire bus_req_t bus_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire logic [7:0] p1_pin_i,
  output logic [7:0] p1_pin_o,
  output logic [7:0] p1_pin_oe_o,
  input wire logic [2:0] p2_pin_i,
  output logic [2:0] p2_pin_o,
  output logic [2:0] p2_pin_oe_o,
  input wire logic [2:0] p3_int_pin_i,
  input wire logic [7:0] seg_data_i,
  input wire logic dual_clock_i,
  input wire logic low_freq_osc_out_i,
  output logic low_freq_osc_in_o,
  input wire logic stop_mode_i,
  input wire logic output_hold_control_i,
  output logic stop_pin_fall_o,
  output logic [2:0] int_route_o
);

  localparam state_t STATE_RST = '{
    p1_latch: P1_LATCH_RST,
    p2_latch: P2_LATCH_RST,
    p1_lcd: P1_LCD_RST,
    route: ROUTE_RST,
    default: '0
  };

  state_t s;
  state_t next_s;
  logic [7:0] p1_sync;
  logic [2:0] p2_sync;
  logic [2:0] p3_sync;
  logic hold;

  // pins come from outside the clock domain
  sync2 #(.W(P1_W)) u_sync_p1 (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(p1_pin_i),
    .q_o(p1_sync)
  );

  sync2 #(.W(P2_W)) u_sync_p2 (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(p2_pin_i),
    .q_o(p2_sync)
  );

  sync2 #(.W(ROUTE_INT_W)) u_sync_p3 (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(p3_int_pin_i),
    .q_o(p3_sync)
  );

  // in stop mode the pins only keep driving if hold is requested, except the oscillator output in dual-clock mode
  assign hold = !stop_mode_i || output_hold_control_i;

  always_comb begin
    next_s = s;
    // write is taken in the first state, applied in the second
    next_s.wr_pend = bus_i.wr;
    next_s.wr_addr = bus_i.addr;
    next_s.wr_data = bus_i.wdata;
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        ADDR_P1_LATCH: next_s.p1_latch = s.wr_data;
        ADDR_P2_LATCH: next_s.p2_latch = s.wr_data[P2_W-1:0];
        ADDR_P1_LCD: next_s.p1_lcd = s.wr_data;
        ADDR_ROUTE: next_s.route = s.wr_data;
        default: ; // pin-read and other addresses: write dropped
      endcase
    end
    // pin values sampled at the first bus state of the read
    next_s.rvalid = bus_i.rd;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_P1_LATCH: next_s.rdata = s.p1_latch;
        ADDR_P1_PIN: next_s.rdata = p1_sync;
        ADDR_P2_LATCH: next_s.rdata = {5'h00, s.p2_latch};
        ADDR_P2_PIN: next_s.rdata = {5'h00, p2_sync};
        ADDR_P1_LCD: next_s.rdata = s.p1_lcd;
        ADDR_ROUTE: next_s.rdata = {1'b0, s.route[ROUTE_BIT7-1:0]};
        default: next_s.rdata = 8'h00; // unmapped reads give zero
      endcase
    end
    // port 1: segment data wins over the latch; latch 1 releases the pin
    for (int i = 0; i < P1_W; i++) begin
      next_s.p1_out[i] = s.p1_lcd[i] ? seg_data_i[i] : 1'b0;
      next_s.p1_oe[i] = (s.p1_lcd[i] || !s.p1_latch[i]) && hold;
    end
    // port 2 stop pin floats in stop mode whatever hold says
    next_s.p2_out[P2_STOP_BIT] = 1'b0;
    next_s.p2_oe[P2_STOP_BIT] = !s.p2_latch[P2_STOP_BIT] &&
      !stop_mode_i;
    // oscillator pins belong to the resonator in dual-clock mode
    next_s.p2_out[P2_OSC_IN_BIT] = 1'b0;
    next_s.p2_oe[P2_OSC_IN_BIT] = !dual_clock_i &&
      !s.p2_latch[P2_OSC_IN_BIT] && hold;
    next_s.p2_out[P2_OSC_OUT_BIT] = dual_clock_i && low_freq_osc_out_i;
    next_s.p2_oe[P2_OSC_OUT_BIT] = dual_clock_i ||
      (!s.p2_latch[P2_OSC_OUT_BIT] && hold);
    next_s.osc_in = dual_clock_i && p2_sync[P2_OSC_IN_BIT];
    // pin level, not latch, so a driven low pulse still flags
    next_s.p20_prev = p2_sync[P2_STOP_BIT];
    next_s.int0 = s.p20_prev && !p2_sync[P2_STOP_BIT];
    // interrupt inputs follow the route select bits
    for (int k = 0; k < ROUTE_INT_W; k++) begin
      next_s.int_route[k] = s.route[ROUTE_INT1_BIT + k] ?
        p3_sync[k] : p1_sync[P1_INT1_BIT + k];
    end
  end

  // latches take all-ones at reset, lcd select and route take zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign rvalid_o = s.rvalid;
  assign p1_pin_o = s.p1_out;
  assign p1_pin_oe_o = s.p1_oe;
  assign p2_pin_o = s.p2_out;
  assign p2_pin_oe_o = s.p2_oe;
  assign low_freq_osc_in_o = s.osc_in;
  assign stop_pin_fall_o = s.int0;
  assign int_route_o = s.int_route;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_P1_WRITE_S2: assert property (
    bus_i.wr && bus_i.addr == ADDR_P1_LATCH |=> ##1
      s.p1_latch == $past(bus_i.wdata, 2))
    else $error("port1 latch not updated in second state");

  AST_P1_PIN_READ: assert property (
    bus_i.rd && bus_i.addr == ADDR_P1_PIN |=>
      rdata_o == $past(p1_sync) && rvalid_o)
    else $error("port1 pin read wrong");

  AST_P1_LATCH_READ: assert property (
    bus_i.rd && bus_i.addr == ADDR_P1_LATCH |=>
      rdata_o == $past(s.p1_latch))
    else $error("port1 latch read wrong");

  AST_P2_READ_HIGH_ZERO: assert property (
    bus_i.rd && (bus_i.addr == ADDR_P2_PIN ||
      bus_i.addr == ADDR_P2_LATCH) |=> rdata_o[7:3] == 5'h00)
    else $error("port2 read upper bits not zero");

  AST_LCD_DRIVE: assert property (
    s.p1_lcd[0] && hold |=> p1_pin_oe_o[0] &&
      p1_pin_o[0] == $past(seg_data_i[0]))
    else $error("segment drive missing on port1 bit0");

  AST_STOP_FLOAT: assert property (
    stop_mode_i |=> !p2_pin_oe_o[P2_STOP_BIT])
    else $error("stop pin driven in stop mode");

  AST_DUAL_CLOCK: assert property (
    dual_clock_i |=> !p2_pin_oe_o[P2_OSC_IN_BIT] &&
      p2_pin_oe_o[P2_OSC_OUT_BIT])
    else $error("oscillator pins wrong in dual clock mode");

  AST_STOP_FALL: assert property (
    $fell(p2_sync[P2_STOP_BIT]) |=> stop_pin_fall_o ##1
      !stop_pin_fall_o)
    else $error("stop pin falling edge not flagged once");

  AST_PIN_WRITE_IGNORED: assert property (
    bus_i.wr && bus_i.addr == ADDR_P1_PIN && !s.wr_pend |=> ##1
      s.p1_latch == $past(s.p1_latch, 2) &&
      s.p1_lcd == $past(s.p1_lcd, 2))
    else $error("write to pin read changed state");

  AST_ROUTE_INT1: assert property (
    s.route[ROUTE_INT1_BIT] |=> int_route_o[0] == $past(p3_sync[0]))
    else $error("interrupt route select ignored");

  // route select clear keeps the interrupt on its port-1 pin
  AST_ROUTE_P1: assert property (
    !s.route[ROUTE_INT1_BIT] |=>
      int_route_o[0] == $past(p1_sync[P1_INT1_BIT]))
    else $error("interrupt not taken from port1 pin");

  // the last routed interrupt follows its own select bit
  AST_ROUTE_LAST: assert property (
    s.route[ROUTE_INT1_BIT + ROUTE_INT_W - 1] |=>
      int_route_o[ROUTE_INT_W-1] == $past(p3_sync[ROUTE_INT_W-1]))
    else $error("last interrupt route select ignored");

  // port2 latch write lands in the second bus state
  AST_P2_WRITE_S2: assert property (
    bus_i.wr && bus_i.addr == ADDR_P2_LATCH |=> ##1
      s.p2_latch == $past(bus_i.wdata[P2_W-1:0], 2))
    else $error("port2 latch not updated in second state");

  // port2 latch and pin states come from separate addresses
  AST_P2_LATCH_READ: assert property (
    bus_i.rd && bus_i.addr == ADDR_P2_LATCH |=>
      rdata_o[P2_W-1:0] == $past(s.p2_latch) && rvalid_o)
    else $error("port2 latch read wrong");

  AST_P2_PIN_READ: assert property (
    bus_i.rd && bus_i.addr == ADDR_P2_PIN |=>
      rdata_o[P2_W-1:0] == $past(p2_sync) && rvalid_o)
    else $error("port2 pin read wrong");

  // a write aimed at the port2 pin address changes nothing
  AST_P2_PIN_WRITE_IGNORED: assert property (
    bus_i.wr && bus_i.addr == ADDR_P2_PIN && !s.wr_pend |=> ##1
      s.p2_latch == $past(s.p2_latch, 2) &&
      s.route == $past(s.route, 2))
    else $error("write to port2 pin read changed state");

  // read valid only ever follows a read strobe
  AST_RVALID_PULSE: assert property (
    !bus_i.rd |=> !rvalid_o)
    else $error("read valid without a read");

  // first edge out of reset still sees the all-ones latches and the all-zero lcd select
  AST_RESET_LATCHES: assert property (
    $rose(arst_n_i) |-> s.p1_latch == P1_LATCH_RST &&
      s.p2_latch == P2_LATCH_RST && s.p1_lcd == P1_LCD_RST)
    else $error("latches not at reset value after reset");

  // a latch bit of 0 pulls its port1 pin low
  AST_P1_DRIVE_LOW: assert property (
    !s.p1_latch[P1_W-1] && !s.p1_lcd[P1_W-1] && hold |=>
      p1_pin_oe_o[P1_W-1] && !p1_pin_o[P1_W-1])
    else $error("port1 latch zero not driven low");

  AST_P1_RELEASE: assert property (
    s.p1_latch[P1_W-1] && !s.p1_lcd[P1_W-1] |=> !p1_pin_oe_o[P1_W-1])
    else $error("port1 latch one still drives pin");

  AST_P1_NONSEG_LOW: assert property (
    !s.p1_lcd[0] |=> !p1_pin_o[0])
    else $error("segment data on a non-segment pin");

  // the stop pin as an output is driven low while its latch is 0
  AST_STOP_PIN_DRIVE: assert property (
    !s.p2_latch[P2_STOP_BIT] && !stop_mode_i |=>
      p2_pin_oe_o[P2_STOP_BIT] && !p2_pin_o[P2_STOP_BIT])
    else $error("stop pin not driven low from latch");

  AST_STOP_NO_FALSE_PULSE: assert property (
    !$fell(p2_sync[P2_STOP_BIT]) |=> !stop_pin_fall_o)
    else $error("stop pin pulse without a falling edge");

  AST_OSC_IN_SINGLE: assert property (
    !dual_clock_i |=> !low_freq_osc_in_o)
    else $error("oscillator input active in single clock mode");

  // dual-clock mode carries the resonator on both pins
  AST_OSC_FOLLOW: assert property (
    dual_clock_i |=> low_freq_osc_in_o == $past(p2_sync[P2_OSC_IN_BIT]) &&
      p2_pin_o[P2_OSC_OUT_BIT] == $past(low_freq_osc_out_i))
    else $error("oscillator pins not following in dual clock mode");

  COV_P1_WRITE: cover property (
    bus_i.wr && bus_i.addr == ADDR_P1_LATCH ##2 s.p1_latch == 8'h00);
  COV_LCD_ON: cover property (s.p1_lcd == 8'hff);
  COV_STOP_HOLD: cover property (stop_mode_i && output_hold_control_i);
  COV_FALL: cover property (stop_pin_fall_o);
  COV_DUAL_OSC: cover property (dual_clock_i && low_freq_osc_in_o);

endmodule : gpio_port

// ==== core/gpio_port_pkg.sv ====
package gpio_port_pkg;

  // register addresses on the memory-mapped bus
  localparam logic [11:0] ADDR_P1_LATCH = 12'h001;
  localparam logic [11:0] ADDR_P2_LATCH = 12'h002;
  localparam logic [11:0] ADDR_P1_PIN = 12'h008;
  localparam logic [11:0] ADDR_P2_PIN = 12'h009;
  localparam logic [11:0] ADDR_P1_LCD = 12'h029;
  localparam logic [11:0] ADDR_ROUTE = 12'hfc0;

  // widths
  localparam int P1_W = 8;
  localparam int P2_W = 3;
  localparam int ROUTE_INT_W = 3;

  // reset values
  localparam logic [7:0] P1_LATCH_RST = 8'hff;
  localparam logic [2:0] P2_LATCH_RST = 3'h7;
  localparam logic [7:0] P1_LCD_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;

  // field positions
  localparam int ROUTE_INT1_BIT = 4;
  localparam int ROUTE_BIT7 = 7;
  localparam int P2_STOP_BIT = 0;
  localparam int P2_OSC_IN_BIT = 1;
  localparam int P2_OSC_OUT_BIT = 2;
  localparam int P1_INT1_BIT = 2;

  // register bus request from the processor
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // full state of the port block
  typedef struct packed {
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] p1_latch;
    logic [7:0] p1_lcd;
    logic [7:0] route;
    logic [2:0] p2_latch;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
    logic [2:0] p2_out;
    logic [2:0] p2_oe;
    logic p20_prev;
    logic int0;
    logic [2:0] int_route;
    logic osc_in;
  } state_t;

endpackage : gpio_port_pkg

// ==== core/sync2.sv ====
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t s;
  sync_st_t next_s;

  // the meta stage feeds only the second stage
  always_comb begin
    next_s.meta = d_i;
    next_s.q = s.meta;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;

endmodule : sync2

// ==== testbench/gpio_board.sv ====
`timescale 1ns/1ps
// board side of the pins: open-drain style with pull-ups, and the
// board holds its own drive still between samples
module gpio_board (
  input wire logic [7:0] p1_out_i,
  input wire logic [7:0] p1_oe_i,
  input wire logic [7:0] p1_ext_i,
  output logic [7:0] p1_pin_o,
  input wire logic [2:0] p2_out_i,
  input wire logic [2:0] p2_oe_i,
  input wire logic [2:0] p2_ext_i,
  output logic [2:0] p2_pin_o
);
  // a driven bit wins, a released bit shows the board level
  assign p1_pin_o = (p1_oe_i & p1_out_i) | (~p1_oe_i & p1_ext_i);
  assign p2_pin_o = (p2_oe_i & p2_out_i) | (~p2_oe_i & p2_ext_i);
endmodule : gpio_board

// ==== testbench/gpio_port_p1_p2_tb.sv ====
`timescale 1ns/1ps
module gpio_port_p1_p2_tb;
  import gpio_port_pkg::*;
  logic clk_i = 0;
  logic arst_n_i = 0;
  bus_req_t bus = '0;
  logic [7:0] rdata, p1_pin, p1_o, p1_oe, v, s;
  logic [7:0] seg = 8'h00, e1 = 8'hff;
  logic [2:0] p2_pin, p2_o, p2_oe, rt, p3 = 3'h0, e2 = 3'h7;
  logic rvalid, osc_in, fall, dual = 0, osc_out = 0, stop = 0, hold = 1;
  int n_errors = 0, tests_run = 0, cyc = 0, n_fall = 0;

  always #20 clk_i = ~clk_i;

  // hang guard: the sequence needs about 360 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (fall === 1'b1) n_fall++;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end

  gpio_port u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus),
    .rdata_o(rdata), .rvalid_o(rvalid), .p1_pin_i(p1_pin),
    .p1_pin_o(p1_o), .p1_pin_oe_o(p1_oe), .p2_pin_i(p2_pin),
    .p2_pin_o(p2_o), .p2_pin_oe_o(p2_oe), .p3_int_pin_i(p3),
    .seg_data_i(seg), .dual_clock_i(dual), .low_freq_osc_out_i(osc_out),
    .low_freq_osc_in_o(osc_in), .stop_mode_i(stop),
    .output_hold_control_i(hold), .stop_pin_fall_o(fall),
    .int_route_o(rt));

  gpio_board u_board (.p1_out_i(p1_o), .p1_oe_i(p1_oe), .p1_ext_i(e1),
    .p1_pin_o(p1_pin), .p2_out_i(p2_o), .p2_oe_i(p2_oe),
    .p2_ext_i(e2), .p2_pin_o(p2_pin));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // a latch bit of 0 pulls low, 1 releases the pin to the board
  function automatic logic [7:0] od(input logic [7:0] l, x);
    return l & x;
  endfunction : od

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // whole-byte write; waits out the latch and pin update plus sync
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_i);
    bus.wr <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] m, e);
    @(posedge clk_i);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(8'h01, {7'h0, rvalid});
    chk(e & m, rdata & m);
  endtask : rd

  task automatic results();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // main sequence; reserved addresses are never touched
  initial begin
    s = 8'h40;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(ADDR_P1_LATCH, 8'hff, 8'hff);
    rd(ADDR_P2_LATCH, 8'h07, 8'h07);
    rd(ADDR_P1_LCD, 8'hff, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = lfsr(s);
      s = lfsr(v);
      e1 <= s;
      wr(ADDR_P1_LATCH, v);
      rd(ADDR_P1_LATCH, 8'hff, v);
      rd(ADDR_P1_PIN, 8'hff, od(v, s));
      wr(ADDR_P1_PIN, ~v);
      rd(ADDR_P1_LATCH, 8'hff, v);
      wr(ADDR_P2_LATCH, v);
      rd(ADDR_P2_LATCH, 8'h07, v);
      rd(ADDR_P2_PIN, 8'h07, od(v, 8'h07));
      wr(ADDR_P2_PIN, ~v);
      rd(ADDR_P2_LATCH, 8'h07, v);
    end
    // corner case: every pin driven low, board level hidden
    wr(ADDR_P1_LATCH, 8'h00);
    rd(ADDR_P1_PIN, 8'hff, 8'h00);
    // upper half released to the board, lower half segments
    seg <= s;
    wr(ADDR_P1_LATCH, 8'hf0);
    wr(ADDR_P1_LCD, 8'h0f);
    chk(s & 8'h0f, p1_o);
    chk(8'h0f, p1_oe);
    rd(ADDR_P1_PIN, 8'hf0, od(8'hf0, s));
    wr(ADDR_P1_LCD, 8'h00);
    wr(ADDR_P1_LATCH, 8'hff);
    wr(ADDR_P2_LATCH, 8'h07);
    n_fall = 0;
    wr(ADDR_P2_LATCH, 8'h06);
    // the pulse trails the pin by two sync stages and one flop
    repeat (2) @(posedge clk_i);
    chk(8'h01, n_fall[7:0]);
    // stop floats the stop pin even with output hold set
    stop <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(8'h00, {7'h0, p2_oe[0]});
    stop <= 1'b0;
    dual <= 1'b1;
    osc_out <= 1'b1;
    e2 <= 3'h3;
    repeat (5) @(posedge clk_i);
    chk(8'h07, {5'h0, p2_oe[2], osc_in, p2_o[2]});
    dual <= 1'b0;
    e2 <= 3'h7;
    repeat (5) @(posedge clk_i);
    chk(8'h00, {6'h0, p2_oe[2], osc_in});
    // random routing against random pin levels
    for (int i = 0; i < 5; i++) begin
      s = lfsr(s);
      p3 <= s[2:0];
      e1 <= s;
      wr(ADDR_ROUTE, s);
      rd(ADDR_ROUTE, 8'hff, s & 8'h7f);
      chk({5'h0, (s[6:4] & s[2:0]) | (~s[6:4] & s[4:2])}, {5'h0, rt});
    end
    results();
  end
endmodule : gpio_port_p1_p2_tb
